// ===== rtl/ald_pkg.sv
// Shared constants and types of the alphanumeric LED display controller.
package ald_pkg;

   localparam int unsigned NCHAR    = 8;
   localparam int unsigned ADDR_W   = 3;
   localparam int unsigned CNT_W    = 4;
   localparam int unsigned CODE_W   = 6;
   localparam int unsigned NSEG     = 16;
   localparam int unsigned SEG_W    = 17;
   localparam int unsigned NFONT    = 64;
   localparam int unsigned PREDIV_W = 6;
   localparam int unsigned MUX_W    = 3;
   localparam int unsigned LOW_W    = 8;

   localparam logic [CODE_W-1:0]   BLANK_CODE   = 6'h20;
   localparam logic [CNT_W-1:0]    CNT_CLEAR    = 4'h0;
   localparam logic [CNT_W-1:0]    CNT_STEP     = 4'h1;
   localparam int unsigned         FULL_BIT     = 3;
   localparam logic [PREDIV_W-1:0] PREDIV_STEP  = 6'h01;
   localparam logic [PREDIV_W-1:0] PREDIV_BLANK = 6'h3f;
   localparam logic [MUX_W-1:0]    MUX_STEP     = 3'h1;
   localparam logic [LOW_W-1:0]    LOW_STEP     = 8'h01;
   localparam logic [LOW_W-1:0]    SHUT_CYCLES  = 8'hff;
   localparam logic [NCHAR-1:0]    CHAR_ONE     = 8'h01;

   // Timebase that gives the nominal refresh without an external capacitor.
   localparam int unsigned TIMEBASE_HZ = 204800;
   localparam int unsigned PREDIV_DIV  = 64;
   localparam int unsigned MUX_DIV     = 8;
   localparam int unsigned SCAN_HZ     = TIMEBASE_HZ / (PREDIV_DIV * MUX_DIV);

   // Halves of the top and bottom bars, and the point, in the segment vector.
   localparam int unsigned SEG_A1 = 0;
   localparam int unsigned SEG_A2 = 1;
   localparam int unsigned SEG_D1 = 4;
   localparam int unsigned SEG_D2 = 5;
   localparam int unsigned SEG_PT = 16;

   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_MEM0   = 12'h010;
   localparam logic [11:0] ADDR_MEM7   = 12'h02c;
   localparam int unsigned WORD_LSB    = 2;
   localparam int unsigned CTRL_REDUCED = 0;
   localparam int unsigned ST_MODE     = 0;
   localparam int unsigned ST_FULL     = 1;
   localparam int unsigned ST_CHEN     = 2;
   localparam int unsigned ST_SHUT     = 3;
   localparam int unsigned ST_FDRV     = 4;
   localparam int unsigned ST_CNT      = 8;

   typedef enum logic {addressed_entry, auto_increment_entry} ald_mode_e;

   typedef struct packed {
      logic              wr_n;
      logic              cs;
      logic              cs_n;
      logic              mode;
      logic              addr_bit0;
      logic              addr_bit1;
      logic              addr_bit2;
      logic [CODE_W-1:0] char_code_in;
   } ald_wport_s;

   typedef struct packed {
      logic [NCHAR-1:0] char_sel;
      logic [NSEG-1:0]  lamp_lines;
      logic             point_lamp;
   } ald_lamp_s;

   typedef logic [NFONT-1:0][SEG_W-1:0] ald_font_t;

endpackage

// ===== rtl/ald_font.sv
// Character code to segment pattern lookup.
`timescale 1ns/100ps
module ald_font #(
   parameter ald_pkg::ald_font_t FONT = '0
) (
   input  wire logic [ald_pkg::CODE_W-1:0] code,
   output logic      [ald_pkg::SEG_W-1:0]  segs
);

   // The glyphs exist only as drawings, so the table is a parameter.
   always_comb begin
      segs = FONT[code];
   end

endmodule

// ===== rtl/ald_scan.sv
// Timebase pre-divider, multiplex counter and shutdown detector.
`timescale 1ns/100ps
module ald_scan (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      timebase_standby_pin,
   output logic      [ald_pkg::MUX_W-1:0] char_idx,
   output logic                           blank,
   output logic                           shutdown
);

   typedef struct packed {
      logic                         tb;
      logic [ald_pkg::PREDIV_W-1:0] prediv;
      logic [ald_pkg::MUX_W-1:0]    mux;
      logic [ald_pkg::LOW_W-1:0]    low;
      logic                         shut;
   } ald_scan_s;

   ald_scan_s s_q;
   ald_scan_s s_d;

   always_comb begin
      s_d    = s_q;
      s_d.tb = timebase_standby_pin;
      // A held low level is told apart from the low half of a tick by time.
      if (timebase_standby_pin) begin
         s_d.low  = '0;
         s_d.shut = 1'b0;
      end else if (s_q.low != ald_pkg::SHUT_CYCLES) begin
         s_d.low = s_q.low + ald_pkg::LOW_STEP;
      end else begin
         s_d.shut = 1'b1;
      end
      if (s_q.shut) begin
         s_d.prediv = '0;
         s_d.mux    = '0;
      end else if (timebase_standby_pin && !s_q.tb) begin
         s_d.prediv = s_q.prediv + ald_pkg::PREDIV_STEP;
         if (s_q.prediv == ald_pkg::PREDIV_BLANK) begin
            s_d.mux = s_q.mux + ald_pkg::MUX_STEP;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q    <= '0;
         // Starting high keeps a high pin after reset from counting a tick.
         s_q.tb <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign char_idx = s_q.mux;
   assign blank    = (s_q.prediv == ald_pkg::PREDIV_BLANK);
   assign shutdown = s_q.shut;

endmodule

// ===== rtl/ald_ctrl.sv
// Display controller top: write port, character memory, scan and APB.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
module ald_ctrl #(
   parameter ald_pkg::ald_font_t FONT = '0
) (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [11:0]               paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire ald_pkg::ald_wport_s       wport,
   input  wire logic                      timebase_standby_pin,
   output logic                           full_flag_out,
   output logic                           full_flag_oe_n,
   output ald_pkg::ald_lamp_s             lamps,
   output logic                           lamp_oe_n
);

   typedef struct packed {
      ald_pkg::ald_mode_e                         mode;
      logic                                       chain_en;
      logic [ald_pkg::ADDR_W-1:0]                 waddr;
      logic                                       strobe;
      logic [ald_pkg::CNT_W-1:0]                  cnt;
      logic                                       fdrv;
      logic [ald_pkg::NCHAR-1:0][ald_pkg::CODE_W-1:0] mem;
      ald_pkg::ald_lamp_s                         lamps;
      logic                                       lamp_off;
      logic                                       reduced;
      logic [31:0]                                rdata;
   } ald_ctrl_s;

   ald_ctrl_s s_q;
   ald_ctrl_s s_d;

   logic [ald_pkg::MUX_W-1:0]  char_idx;
   logic                       blank;
   logic                       shut;
   logic [ald_pkg::SEG_W-1:0]  font_segs;
   logic [ald_pkg::CODE_W-1:0] rd_code;

   logic                       strobe;
   logic                       start;
   logic                       stop;
   logic                       auto_q;
   logic                       full;
   logic                       eff;
   logic                       wr_active;
   logic                       wipe;
   logic [ald_pkg::ADDR_W-1:0] wloc;
   logic [ald_pkg::ADDR_W-1:0] raddr;
   logic [ald_pkg::SEG_W-1:0]  segs;
   logic                       setup;
   logic                       access;
   logic                       mapped;
   logic                       mem_hit;
   logic [ald_pkg::ADDR_W-1:0] mem_idx;
   logic [11:0]                mem_off;

   ald_scan u_scan (
      .pclk                 (pclk),
      .presetn              (presetn),
      .timebase_standby_pin (timebase_standby_pin),
      .char_idx             (char_idx),
      .blank                (blank),
      .shutdown             (shut)
   );

   ald_font #(
      .FONT (FONT)
   ) u_font (
      .code (rd_code),
      .segs (font_segs)
   );

   // Write port decode. The pins are sampled on pclk, so a strobe shorter
   // than one clock period may be missed.
   always_comb begin
      strobe = !wport.wr_n && wport.cs && !wport.cs_n;
      start  = strobe && !s_q.strobe;
      stop   = !strobe && s_q.strobe;
      auto_q = (s_q.mode == ald_pkg::auto_increment_entry);
      full   = s_q.cnt[ald_pkg::FULL_BIT];
      eff    = auto_q ? (s_q.chain_en && !full) : 1'b1;
      wloc   = auto_q ? s_q.cnt[ald_pkg::ADDR_W-1:0] : s_q.waddr;
      wr_active = s_q.strobe && eff;
      // The clear line is shared with an address bit; it is only live while
      // the latched mode is auto-increment.
      wipe   = auto_q && !wport.addr_bit1;
      raddr  = wr_active ? wloc : char_idx;
   end

   assign rd_code = s_q.mem[raddr];

   always_comb begin
      segs = font_segs;
      if (s_q.reduced) begin
         segs[ald_pkg::SEG_A2] = font_segs[ald_pkg::SEG_A1];
         segs[ald_pkg::SEG_D2] = font_segs[ald_pkg::SEG_D1];
      end
   end

   // APB decode.
   always_comb begin
      setup   = psel && !penable;
      access  = psel && penable;
      mem_off = paddr - ald_pkg::ADDR_MEM0;
      mem_idx = mem_off[ald_pkg::WORD_LSB +: ald_pkg::ADDR_W];
      mem_hit = (paddr >= ald_pkg::ADDR_MEM0) &&
                (paddr <= ald_pkg::ADDR_MEM7) &&
                (paddr[ald_pkg::WORD_LSB-1:0] == 2'h0);
      mapped  = (paddr == ald_pkg::ADDR_CTRL) ||
                (paddr == ald_pkg::ADDR_STATUS) || mem_hit;
   end

   always_comb begin
      s_d        = s_q;
      s_d.strobe = strobe;

      if (start) begin
         s_d.mode = ald_pkg::ald_mode_e'(wport.mode);
         if (!wport.mode) begin
            s_d.waddr = {wport.addr_bit2, wport.addr_bit1,
                         wport.addr_bit0};
            s_d.fdrv  = 1'b0;
         end else begin
            s_d.chain_en = wport.addr_bit0;
         end
      end

      if (stop) begin
         if (eff) begin
            s_d.mem[wloc] = wport.char_code_in;
            if (auto_q) begin
               s_d.cnt = s_q.cnt + ald_pkg::CNT_STEP;
            end
         end
         if (auto_q) begin
            s_d.fdrv = 1'b1;
         end
      end

      if (wipe) begin
         s_d.cnt = ald_pkg::CNT_CLEAR;
         for (int i = 0; i < ald_pkg::NCHAR; i++) begin
            s_d.mem[i] = ald_pkg::BLANK_CODE;
         end
      end

      // Display output register. Shutdown leaves the memory untouched.
      s_d.lamp_off = shut;
      if (wr_active || shut || blank) begin
         s_d.lamps = '0;
      end else begin
         s_d.lamps.char_sel   = ald_pkg::CHAR_ONE << char_idx;
         s_d.lamps.lamp_lines = segs[ald_pkg::NSEG-1:0];
         s_d.lamps.point_lamp = segs[ald_pkg::SEG_PT];
      end

      // Read data is taken in the setup cycle so it comes from a flop.
      if (setup) begin
         s_d.rdata = '0;
         if (paddr == ald_pkg::ADDR_CTRL) begin
            s_d.rdata[ald_pkg::CTRL_REDUCED] = s_q.reduced;
         end else if (paddr == ald_pkg::ADDR_STATUS) begin
            s_d.rdata[ald_pkg::ST_MODE] = auto_q;
            s_d.rdata[ald_pkg::ST_FULL] = full;
            s_d.rdata[ald_pkg::ST_CHEN] = s_q.chain_en;
            s_d.rdata[ald_pkg::ST_SHUT] = shut;
            s_d.rdata[ald_pkg::ST_FDRV] = s_q.fdrv;
            s_d.rdata[ald_pkg::ST_CNT +: ald_pkg::CNT_W] = s_q.cnt;
         end else if (mem_hit) begin
            s_d.rdata[ald_pkg::CODE_W-1:0] = s_q.mem[mem_idx];
         end
      end
      if (access && pwrite && (paddr == ald_pkg::ADDR_CTRL)) begin
         s_d.reduced = pwdata[ald_pkg::CTRL_REDUCED];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q          <= '0;
         s_q.mode     <= ald_pkg::addressed_entry;
         s_q.lamp_off <= 1'b1;
         for (int i = 0; i < ald_pkg::NCHAR; i++) begin
            s_q.mem[i] <= ald_pkg::BLANK_CODE;
         end
      end else begin
         s_q <= s_d;
      end
   end

   assign pready  = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata  = s_q.rdata;

   // The shared pin is released in shutdown so another driver may own it.
   assign full_flag_out  = full;
   assign full_flag_oe_n = !(s_q.fdrv && !shut);
   assign lamps          = s_q.lamps;
   assign lamp_oe_n      = s_q.lamp_off;

endmodule

// ===== verif/ald_ctrl_props.sv
// Port checks for the display controller.
`timescale 1ns/100ps
module ald_ctrl_props (
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic [11:0]         paddr,
   input wire logic                pready,
   input wire logic                pslverr,
   input wire ald_pkg::ald_wport_s wport,
   input wire logic                timebase_standby_pin,
   input wire logic                full_flag_oe_n,
   input wire ald_pkg::ald_lamp_s  lamps,
   input wire logic                lamp_oe_n
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic       stb;
   logic       stb_q;
   logic       lm_q;
   logic       map;
   logic [8:0] low_q;
   assign stb = !wport.wr_n & wport.cs & !wport.cs_n;
   assign map = paddr == 12'h000 || paddr == 12'h004 ||
                (paddr >= 12'h010 && paddr <= 12'h02c && paddr[1:0] == 2'h0);
   // The latched mode is rebuilt here so write blanking can be judged.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stb_q <= 1'b0;
         lm_q  <= 1'b0;
         low_q <= 9'h000;
      end else begin
         stb_q <= stb;
         if (stb && !stb_q) begin
            lm_q <= wport.mode;
         end
         if (timebase_standby_pin) begin
            low_q <= 9'h000;
         end else if (low_q != 9'h1ff) begin
            low_q <= low_q + 9'h001;
         end
      end
   end
   sel_one_hot_a: assert property ($onehot0(lamps.char_sel))
      else $error("several character selects active");
   blank_step_a: assert property (lamps.char_sel != 8'h00 &&
      $changed(lamps.char_sel) |-> $past(lamps.char_sel) == 8'h00)
      else $error("select moved without a blank gap");
   write_dark_a: assert property (stb && $past(stb) && $past(stb, 2) &&
      !lm_q |-> lamps == '0) else $error("lamps lit during a write");
   shut_release_a: assert property (low_q >= 9'h120 |->
      lamp_oe_n && full_flag_oe_n) else $error("outputs driven in shutdown");
   shut_dark_a: assert property (lamp_oe_n |-> lamps == '0)
      else $error("lamps active while released");
   flag_drive_a: assert property ($fell(full_flag_oe_n) |-> !stb &&
      ($past(stb) || $past(stb, 2))) else $error("flag driven too early");
   flag_hold_a: assert property ($rose(full_flag_oe_n) |-> $past(stb) ||
      $past(stb, 2) || low_q >= 9'h0f0) else $error("flag released early");
   apb_resp_a: assert property (psel && penable |-> pready &&
      pslverr == !map) else $error("bad bus response");
   cover property (stb && !lm_q);
   cover property ($fell(full_flag_oe_n));
   cover property ($rose(lamp_oe_n));
endmodule
bind ald_ctrl ald_ctrl_props u_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .wport(wport), .lamps(lamps), .lamp_oe_n(lamp_oe_n),
   .timebase_standby_pin(timebase_standby_pin),
   .full_flag_oe_n(full_flag_oe_n));

// ===== verif/ald_host.sv
// Processor bus model that drives the display write port.
`timescale 1ns/100ps
module ald_host (
   input  wire logic           pclk,
   input  wire logic           full_flag_out,
   input  wire logic           full_flag_oe_n,
   output ald_pkg::ald_wport_s wport
);
   ald_pkg::ald_wport_s w = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 6'h00};
   // The host yields the top address line while the flag is driven.
   always_comb begin
      wport = w;
      if (!full_flag_oe_n) begin
         wport.addr_bit2 = full_flag_out;
      end
   end
   task automatic gate(input logic [2:0] e);
      w.wr_n <= !e[0];
      w.cs   <= e[1];
      w.cs_n <= !e[2];
   endtask
   // Input g picks which of the three enables opens and closes the write.
   task automatic wr(input logic m, input logic [2:0] a,
                     input logic [5:0] d, input int g);
      @(posedge pclk);
      w.mode <= m;
      {w.addr_bit2, w.addr_bit1, w.addr_bit0} <= a;
      w.char_code_in <= ~d;
      gate(3'h7 ^ (3'h1 << g));
      @(posedge pclk);
      gate(3'h7);
      @(posedge pclk);
      w.char_code_in <= d;
      if (!m) begin
         {w.addr_bit2, w.addr_bit1, w.addr_bit0} <= ~a;
      end
      repeat (3) @(posedge pclk);
      gate(3'h7 ^ (3'h1 << g));
      @(posedge pclk);
      gate(3'h0);
      w.addr_bit1 <= 1'b1;
   endtask
   task automatic wipe();
      @(posedge pclk);
      w.addr_bit1 <= 1'b0;
      repeat (2) @(posedge pclk);
      w.addr_bit1 <= 1'b1;
   endtask
endmodule

// ===== verif/ald_ctrl_tb_top.sv
// Self-checking bench for the display controller.
`timescale 1ns/100ps
module ald_ctrl_tb_top;
   localparam ald_pkg::ald_font_t FNT = ald_pkg::ald_font_t'(1) << (42 * 17);
   logic                pclk    = 1'b0;
   logic                presetn = 1'b0;
   logic                psel    = 1'b0;
   logic                penable = 1'b0;
   logic                pwrite  = 1'b0;
   logic [11:0]         paddr   = 12'h000;
   logic [31:0]         pwdata  = 32'h0;
   logic                tbase   = 1'b0;
   logic                run     = 1'b1;
   logic [31:0]         prdata;
   logic [31:0]         r;
   logic                pready, pslverr, ffo, ffoe, loe, e;
   ald_pkg::ald_wport_s wport;
   ald_pkg::ald_lamp_s  lamps;
   int                  num_errors = 0;
   int                  checked    = 0;
   int                  n;
   always #10 pclk = ~pclk;
   always @(posedge pclk) tbase <= run ? ~tbase : 1'b0;
   ald_host host (.pclk(pclk), .full_flag_out(ffo), .full_flag_oe_n(ffoe),
      .wport(wport));
   ald_ctrl #(.FONT(FNT)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .wport(wport),
      .timebase_standby_pin(tbase), .full_flag_out(ffo),
      .full_flag_oe_n(ffoe), .lamps(lamps), .lamp_oe_n(loe));
   task automatic end_of_test();
      if (num_errors == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(r, x);
   endtask
   // Waits for a select pattern and counts the cycles spent waiting.
   task automatic waitsel(input logic [7:0] s);
      n = 0;
      while (lamps.char_sel !== s && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      if (n == 2000) begin
         num_errors++;
         $display("[FAIL] %0t select pattern never seen", $time);
      end
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 8; i++) rd(12'h010 + 12'(4 * i), 32'h20);
      rd(12'h004, 32'h0);
      for (int g = 0; g < 3; g++) begin
         host.wr(1'b0, 3'(g + 5), 6'(17 + g), g);
      end
      for (int g = 0; g < 3; g++) rd(12'h024 + 12'(4 * g), 32'(17 + g));
      apb(1'b0, 12'h008, 32'h0);
      chk(32'(e), 32'h1);
      chk(r, 32'h0);
      host.wr(1'b1, 3'b010, 6'h01, 0);
      rd(12'h004, 32'h11);
      rd(12'h024, 32'h11);
      host.wipe();
      rd(12'h024, 32'h20);
      for (int i = 0; i < 8; i++) host.wr(1'b1, 3'b011, 6'(i + 1), 0);
      host.wr(1'b1, 3'b011, 6'h3f, 0);
      for (int i = 0; i < 8; i++) rd(12'h010 + 12'(4 * i), 32'(i + 1));
      rd(12'h004, 32'h817);
      chk(32'(wport.addr_bit2), 32'h1);
      host.wr(1'b0, 3'h0, 6'h2a, 0);
      chk(32'(ffoe), 32'h1);
      rd(12'h010, 32'h2a);
      waitsel(8'h01);
      chk(32'(lamps.lamp_lines), 32'h1);
      apb(1'b1, 12'h000, 32'h1);
      waitsel(8'h80);
      waitsel(8'h01);
      chk(32'(lamps.lamp_lines), 32'h3);
      waitsel(8'h02);
      chk(n, 128);
      run <= 1'b0;
      repeat (300) @(posedge pclk);
      chk(32'(loe), 32'h1);
      chk(32'(lamps), 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk(32'(r[3]), 32'h1);
      rd(12'h010, 32'h2a);
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      end_of_test();
   end
endmodule
